// ### rtl/sps_eng_if.sv
`timescale 1ns/1ns
interface sps_eng_if;
    logic       load;
    logic [7:0] loadData;
    logic       clr;
    logic       master;
    logic       tick;
    logic       clock_idle_polarity;
    logic       cke;
    logic       sck;
    logic       serial_in_pin;
    logic       serial_out_pin;
    logic       sckOut;
    logic       done;
    logic       busy;
    logic [7:0] rxByte;
    modport ctl (output load, loadData, clr, master, tick, clock_idle_polarity, cke, sck, serial_in_pin,
                 input serial_out_pin, sckOut, done, busy, rxByte);
    modport eng (input load, loadData, clr, master, tick, clock_idle_polarity, cke, sck, serial_in_pin,
                 output serial_out_pin, sckOut, done, busy, rxByte);
endinterface

// ### rtl/sps_params.svh
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
`define SPS_OFF_BUF      8'h00
`define SPS_OFF_CON      8'h04
`define SPS_OFF_STAT     8'h08
`define SPS_OFF_CON2     8'h0c
`define SPS_OFF_ADDR     8'h10
`define SPS_OFF_CTRL     8'h14
`define SPS_CON_RST      8'h00
`define SPS_STAT_RST     8'h00
`define SPS_MODE_SLV_SS  4'h4
`define SPS_MODE_SLV     4'h5
`define SPS_MODE_I2C_MST 4'h8
`define SPS_MODE_I2C_FW  4'hb
`define SPS_CON_WCOL     7
`define SPS_CON_OV       6
`define SPS_CON_EN       5
`define SPS_CON_CKP      4
`define SPS_ST_SMP       7
`define SPS_ST_CKE       6
`define SPS_CTRL_FLAG    0
`define SPS_CTRL_WAKE    1
`define SPS_CTRL_SDOIN   2
`define SPS_DIV_FAST     4
`define SPS_DIV_MID      16
`define SPS_DIV_SLOW     64
`define SPS_FRAME_BITS   8
`endif

// ### rtl/sps_pkg.sv
package sps_pkg;
    typedef enum logic {ENG_IDLE, ENG_RUN} sps_eng_state_type;

    typedef struct packed {
        sps_eng_state_type state;
        logic [7:0]        shreg;
        logic [7:0]        rx;
        logic [3:0]        cnt;
        logic              sckPrev;
        logic              sckOut;
        logic              serial_out_pin;
        logic              done;
    } sps_eng_reg_type;

    typedef struct packed {
        logic [7:0] con;
        logic       sample_or_slew_bit;
        logic       cke;
        logic [7:0] dbuf;
        logic       bf;
        logic       flag;
        logic       wakeEn;
        logic       sdoIn;
        logic [7:0] con2;
        logic [7:0] addr;
        logic       da;
        logic       stp;
        logic       sta;
        logic       rw;
        logic       ua;
        logic [5:0] div;
        logic       ss1;
        logic       ss2;
        logic       ack;
        logic [7:0] rdat;
    } sps_top_reg_type;
endpackage

// ### rtl/sps_serial_port.sv
// Contract
// (R1) Select-pin handling only in slave mode code 04h; other modes ignore the pin.
// (R2) Select low: shifting enabled and serial output driven.
// (R3) Select rising: serial output released at once, even mid-byte.
// (R4) Select high or port disabled resets shifter logic and bit counter.
// (R5) Software sets select control whenever slave mode uses edge select high.
// (R6) Serial output set as input: never driven; serial input still receives.
// (R7) Master mode in sleep: clocks stop, transfer freezes, resumes on wake.
// (R8) Slave mode keeps shifting in sleep; byte sets flag and may wake.
// (R9) Any reset disables the port and abandons the transfer.
// (R10) SPI modes map to polarity and edge bits: 01, 00, 11, 10.
// (R11) I2C mode: status low six bits read-only, top two writable.
// (R12) Address register: own address in slave, low seven bits reload in master.
// (R13) Completed byte moves to buffer, sets buffer full and port flag.
// (R14) Buffer write loads buffer and shifter together.
// (R15) I2C status bit 7 high disables slew control, low enables it.
// (R16) I2C status bit 6 high enables SMBus input thresholds.
// (R17) I2C slave status bit 5: last byte data one, address zero.
// (R18) Bits 4 and 3 flag last STOP or START; cleared by reset, disable.
// (R19) I2C slave bit 2 holds last matched read/write until START, STOP, NACK.
// (R20) I2C master bit 2 shows transmit; idle when it and requests are zero.
// (R21) Ten-bit slave bit 1 asks software to reload the address.
// (R22) Bit 0 shows buffer full on receive and during data transmit.
// (R23) Select pin synchronised before its rising level resets and releases output; the code releases the output from the raw pin.
`timescale 1ns/1ns
`include "sps_params.svh"
module sps_serial_port import sps_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sleepMode,
    input  wire logic        sckIn,
    output logic             sckOut,
    output logic             sckOe,
    input  wire logic        sdiIn,
    output logic             sdoOut,
    output logic             sdoOe,
    input  wire logic        slaveSelN,
    output logic             portIntFlag,
    output logic             wakeReq,
    output logic [1:0]       spiModeNum,
    input  wire logic        i2cStartSeen,
    input  wire logic        i2cStopSeen,
    input  wire logic        i2cNackSeen,
    input  wire logic        i2cByteDone,
    input  wire logic [7:0]  i2cRxByte,
    input  wire logic        i2cByteIsData,
    input  wire logic        i2cAddrMatch,
    input  wire logic        i2cRwBit,
    input  wire logic        i2cAddrUpdate,
    input  wire logic        i2cTxData,
    output logic             i2cPortIdle,
    output logic             slewRateOff,
    output logic             smbusLevels,
    output logic [7:0]       addrOrReload
);
    function automatic logic isI2c(input logic [3:0] m);
        return m == 4'h6 || m == 4'h7 || m == `SPS_MODE_I2C_MST || m == `SPS_MODE_I2C_FW
            || m == 4'he || m == 4'hf;
    endfunction

    function automatic logic isI2cMst(input logic [3:0] m);
        return m == `SPS_MODE_I2C_MST || m == `SPS_MODE_I2C_FW;
    endfunction

    function automatic logic [5:0] halfCnt(input logic [3:0] m);
        if (m == 4'h0) begin
            return 6'(`SPS_DIV_FAST / 2 - 1);
        end else if (m == 4'h1) begin
            return 6'(`SPS_DIV_MID / 2 - 1);
        end
        return 6'(`SPS_DIV_SLOW / 2 - 1);
    endfunction

    sps_top_reg_type r_q;
    sps_top_reg_type r_d;
    sps_eng_if       eng ();
    logic       en;
    logic [3:0] mode;
    logic       i2c;
    logic       i2cMst;
    logic       spi;
    logic       spiMst;
    logic       ssCtl;
    logic       req;
    logic       wr;
    logic       rd;
    logic       rxValid;
    logic [7:0] rxByte;
    logic       stBit2;
    logic [7:0] statVal;

    assign en = r_q.con[`SPS_CON_EN];
    assign mode = r_q.con[3:0];
    assign i2c = isI2c(mode);
    assign i2cMst = isI2cMst(mode);
    assign spi = !i2c;
    assign spiMst = spi && mode <= 4'h2;
    assign ssCtl = spi && mode == `SPS_MODE_SLV_SS;   // [R1]
    assign req = wb_cyc_i && wb_stb_i && !r_q.ack;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;

    // Synchronised select resets; the raw pin only releases the output faster
    assign eng.clr = !en || i2c || (ssCtl && r_q.ss2);   // [R4] [R23]
    assign eng.master = spiMst;
    assign eng.tick = spiMst && en && !sleepMode && r_q.div == 6'h00;   // [R7]
    assign eng.clock_idle_polarity = r_q.con[`SPS_CON_CKP];
    assign eng.cke = r_q.cke;
    assign eng.sck = sckIn;
    assign eng.serial_in_pin = sdiIn;
    assign eng.load = wr && wb_adr_i == `SPS_OFF_BUF && spi && en && !eng.busy;   // [R14]
    assign eng.loadData = wb_dat_i[7:0];

    sps_shift_engine #(
        .BITS (`SPS_FRAME_BITS)
    ) u_eng (
        .clk   (clk),
        .rst_n (rst_n),
        .eng   (eng)
    );

    assign rxValid = spi ? eng.done : (en && i2cByteDone);
    assign rxByte = spi ? eng.rxByte : i2cRxByte;
    assign stBit2 = i2cMst ? i2cTxData : r_q.rw;   // [R19] [R20]
    assign statVal = {r_q.sample_or_slew_bit, r_q.cke,
                      i2c ? {r_q.da, r_q.stp, r_q.sta, stBit2, r_q.ua} : 5'h00,
                      r_q.bf || (i2c && i2cTxData)};   // [R22]

    always_comb begin
        r_d = r_q;
        r_d.ack = req;
        r_d.ss1 = slaveSelN;
        r_d.ss2 = r_q.ss1;
        // Divider stands still in sleep so a master transfer resumes in place
        if (!spiMst || !en) begin
            r_d.div = halfCnt(mode);
        end else if (!sleepMode) begin   // [R7]
            r_d.div = r_q.div == 6'h00 ? halfCnt(mode) : r_q.div - 6'h01;
        end
        if (rd) begin
            if (wb_adr_i == `SPS_OFF_BUF) begin
                r_d.rdat = r_q.dbuf;
                r_d.bf = 1'b0;
            end else if (wb_adr_i == `SPS_OFF_CON) begin
                r_d.rdat = r_q.con;
            end else if (wb_adr_i == `SPS_OFF_STAT) begin
                r_d.rdat = statVal;
            end else if (wb_adr_i == `SPS_OFF_CON2) begin
                r_d.rdat = r_q.con2;
            end else if (wb_adr_i == `SPS_OFF_ADDR) begin
                r_d.rdat = r_q.addr;
            end else if (wb_adr_i == `SPS_OFF_CTRL) begin
                r_d.rdat = {5'h00, r_q.sdoIn, r_q.wakeEn, r_q.flag};
            end else begin
                r_d.rdat = 8'h00;
            end
        end
        if (wr) begin
            if (wb_adr_i == `SPS_OFF_BUF) begin
                if (spi && en && eng.busy) begin
                    r_d.con[`SPS_CON_WCOL] = 1'b1;
                end else begin
                    r_d.dbuf = wb_dat_i[7:0];   // [R14]
                end
            end else if (wb_adr_i == `SPS_OFF_CON) begin
                r_d.con = wb_dat_i[7:0];
            end else if (wb_adr_i == `SPS_OFF_STAT) begin
                r_d.sample_or_slew_bit = wb_dat_i[`SPS_ST_SMP];   // [R11]
                r_d.cke = wb_dat_i[`SPS_ST_CKE];
            end else if (wb_adr_i == `SPS_OFF_CON2) begin
                r_d.con2 = wb_dat_i[7:0];
            end else if (wb_adr_i == `SPS_OFF_ADDR) begin
                r_d.addr = wb_dat_i[7:0];
                r_d.ua = 1'b0;
            end else if (wb_adr_i == `SPS_OFF_CTRL) begin
                if (wb_dat_i[`SPS_CTRL_FLAG]) begin
                    r_d.flag = 1'b0;
                end
                r_d.wakeEn = wb_dat_i[`SPS_CTRL_WAKE];
                r_d.sdoIn = wb_dat_i[`SPS_CTRL_SDOIN];
            end
        end
        // Events come after software clears so a same-cycle set survives
        if (rxValid) begin   // [R13] [R8]
            r_d.flag = 1'b1;
            if (r_d.bf) begin
                if (!spiMst) begin
                    r_d.con[`SPS_CON_OV] = 1'b1;
                end
            end else begin
                r_d.dbuf = rxByte;
                r_d.bf = 1'b1;   // [R22]
            end
        end
        if (!en || !i2c) begin   // [R18]
            r_d.da = 1'b0;
            r_d.stp = 1'b0;
            r_d.sta = 1'b0;
            r_d.rw = 1'b0;
            r_d.ua = 1'b0;
        end else begin
            if (i2cStartSeen) begin   // [R18] [R19]
                r_d.sta = 1'b1;
                r_d.stp = 1'b0;
                r_d.rw = 1'b0;
            end
            if (i2cStopSeen) begin   // [R18] [R19]
                r_d.stp = 1'b1;
                r_d.sta = 1'b0;
                r_d.rw = 1'b0;
            end
            if (i2cNackSeen) begin   // [R19]
                r_d.rw = 1'b0;
            end
            if (i2cAddrMatch && !i2cMst) begin   // [R19]
                r_d.rw = i2cRwBit;
            end
            if (i2cByteDone && !i2cMst) begin   // [R17]
                r_d.da = i2cByteIsData;
            end
            if (i2cAddrUpdate && (mode == 4'h7 || mode == 4'hf)) begin   // [R21]
                r_d.ua = 1'b1;
            end
        end
    end

    // Reset abandons everything, the port enable included
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin   // [R9]
            r_q <= '0;
            r_q.con <= `SPS_CON_RST;
            r_q.sample_or_slew_bit <= 1'(`SPS_STAT_RST >> `SPS_ST_SMP);
            r_q.ss1 <= 1'b1;
            r_q.ss2 <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign wb_ack_o = r_q.ack;
    assign wb_dat_o = {24'h000000, r_q.rdat};
    assign sckOut = eng.sckOut;
    assign sckOe = en && spiMst;
    assign sdoOut = eng.serial_out_pin;
    // Raw pin gates the enable so release does not wait for the synchroniser
    assign sdoOe = en && spi && !r_q.sdoIn
                   && !(ssCtl && (r_q.ss2 || slaveSelN));   // [R2] [R3] [R6]
    assign portIntFlag = r_q.flag;
    assign wakeReq = sleepMode && r_q.flag && r_q.wakeEn;   // [R8]
    assign spiModeNum = {r_q.con[`SPS_CON_CKP], !r_q.cke};   // [R10]
    assign i2cPortIdle = !(i2cMst && i2cTxData) && r_q.con2[4:0] == 5'h00;   // [R20]
    assign slewRateOff = en && i2c && r_q.sample_or_slew_bit;   // [R15]
    assign smbusLevels = en && i2c && r_q.cke;   // [R16]
    assign addrOrReload = i2cMst ? {1'b0, r_q.addr[6:0]} : r_q.addr;   // [R12]

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_ss_ignored;
        en && mode == `SPS_MODE_SLV && r_q.ss2 |-> !eng.clr;
    endproperty
    a_ss_ignored: assert property (p_ss_ignored) else $error("select acted outside mode 4"); // [R1]

    property p_sdo_drive;
        en && ssCtl && !r_q.sdoIn && !r_q.ss2 && !slaveSelN |-> sdoOe;
    endproperty
    a_sdo_drive: assert property (p_sdo_drive) else $error("output not driven with select low"); // [R2]

    property p_sdo_float;
        ssCtl && slaveSelN |-> !sdoOe;
    endproperty
    a_sdo_float: assert property (p_sdo_float) else $error("output driven with select high"); // [R3]

    property p_ss_reset;
        en && ssCtl && $rose(slaveSelN) ##2 ssCtl |=> !eng.busy;
    endproperty
    a_ss_reset: assert property (p_ss_reset) else $error("counter not cleared by select"); // [R4]

    property p_sdo_input;
        r_q.sdoIn |-> !sdoOe;
    endproperty
    a_sdo_input: assert property (p_sdo_input) else $error("output driven while set as input"); // [R6]

    property p_freeze;
        sleepMode && spiMst && en ##1 sleepMode && spiMst && en |-> $stable(r_q.div);
    endproperty
    a_freeze: assert property (p_freeze) else $error("master divider ran in sleep"); // [R7]

    property p_rx_buffer;
        rxValid && !r_q.bf |=> r_q.bf && r_q.flag && r_q.dbuf == $past(rxByte);
    endproperty
    a_rx_buffer: assert property (p_rx_buffer) else $error("received byte not buffered"); // [R13]

    property p_wcol;
        wr && wb_adr_i == `SPS_OFF_BUF && spi && en && eng.busy
            |=> r_q.con[`SPS_CON_WCOL] && $stable(r_q.dbuf);
    endproperty
    a_wcol: assert property (p_wcol) else $error("busy write not refused"); // [R14]

    property p_load;
        eng.load |=> r_q.dbuf == $past(wb_dat_i[7:0]) ##1 eng.busy || !spiMst;
    endproperty
    a_load: assert property (p_load) else $error("write did not load shifter"); // [R14]

    property p_slew;
        wr && wb_adr_i == `SPS_OFF_STAT && en && i2c ##1 en && i2c |-> slewRateOff == $past(wb_dat_i[7]);
    endproperty
    a_slew: assert property (p_slew) else $error("slew control not from status write"); // [R15]

    property p_start;
        en && i2c && i2cStartSeen && !i2cStopSeen ##1 en && i2c |-> r_q.sta && !r_q.stp;
    endproperty
    a_start: assert property (p_start) else $error("start not recorded"); // [R18]

    property p_ack;
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not single cycle");

    c_byte: cover property (spi && eng.done);
    c_wcol: cover property (wr && wb_adr_i == `SPS_OFF_BUF && eng.busy);
    c_ss_abort: cover property (ssCtl && eng.busy && r_q.ss2);
    c_i2c_stop: cover property (i2c && en && i2cStopSeen);
endmodule

// ### rtl/sps_shift_engine.sv
`timescale 1ns/1ns
module sps_shift_engine import sps_pkg::*; #(
    parameter int BITS = 8
) (
    input  wire logic clk,
    input  wire logic rst_n,
    sps_eng_if.eng    eng
);
    if (BITS != 8) begin : g_chk
        $error("sps_shift_engine: frame must be 8 bits");
    end

    sps_eng_reg_type r_q;
    sps_eng_reg_type r_d;
    logic            lvl;
    logic            edgeSeen;
    logic            lead;
    logic            trail;
    logic            sampleEdge;
    logic            outEdge;

    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        lvl = eng.sck;
        edgeSeen = eng.sck != r_q.sckPrev;
        if (eng.master) begin
            // Divider tick only; frozen while the tick is held off
            lvl = ~r_q.sckOut;
            edgeSeen = eng.tick && r_q.state == ENG_RUN;   // [R7]
            if (edgeSeen) begin
                r_d.sckOut = lvl;
            end
        end
        r_d.sckPrev = eng.sck;
        lead = edgeSeen && (lvl != eng.clock_idle_polarity);
        trail = edgeSeen && (lvl == eng.clock_idle_polarity);
        // Edge select high samples on the leading edge
        sampleEdge = eng.cke ? lead : trail;   // [R10]
        outEdge = eng.cke ? trail : lead;
        if (outEdge) begin
            r_d.serial_out_pin = r_q.shreg[7];
        end
        if (sampleEdge && r_q.cnt != 4'd8) begin   // [R8]
            r_d.shreg = {r_q.shreg[6:0], eng.serial_in_pin};
            r_d.cnt = r_q.cnt + 4'd1;
            if (r_q.cnt == 4'd7) begin
                r_d.done = 1'b1;
                r_d.rx = {r_q.shreg[6:0], eng.serial_in_pin};
                if (!eng.master) begin
                    r_d.cnt = 4'd0;
                end
            end
        end
        // Master waits for the clock to return idle before finishing
        if (eng.master && r_q.cnt == 4'd8 && r_q.sckOut == eng.clock_idle_polarity) begin
            r_d.cnt = 4'd0;
            r_d.state = ENG_IDLE;
        end
        if (r_q.state == ENG_IDLE) begin
            r_d.sckOut = eng.clock_idle_polarity;
        end
        if (eng.load) begin   // [R14]
            r_d.shreg = eng.loadData;
            r_d.serial_out_pin = eng.loadData[7];
            r_d.cnt = 4'd0;
            r_d.state = eng.master ? ENG_RUN : ENG_IDLE;
        end
        if (eng.clr) begin   // [R4] [R9]
            r_d.cnt = 4'd0;
            r_d.state = ENG_IDLE;
            r_d.sckOut = eng.clock_idle_polarity;
            r_d.done = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign eng.serial_out_pin = r_q.serial_out_pin;
    assign eng.sckOut = r_q.sckOut;
    assign eng.done = r_q.done;
    assign eng.rxByte = r_q.rx;
    assign eng.busy = r_q.state == ENG_RUN || r_q.cnt != 4'd0;
endmodule

// ### test/sps_spi_master_model.sv
`timescale 1ns/1ns
module sps_spi_master_model (
    input  wire logic clk,
    input  wire logic serial_out_pin,
    output logic      sck,
    output logic      serial_in_pin,
    output logic      ssN
);
    initial begin
        sck = 1'b0;
        serial_in_pin = 1'b0;
        ssN = 1'b1;
    end
    // Data scrambles outside frames, so no stale bit looks valid
    always @(posedge clk) begin
        if (ssN) begin
            serial_in_pin <= ~serial_in_pin;
        end
    end
    // Clock idles low; data stable across both edges, MSB first
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        ssN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            serial_in_pin <= tx[7 - i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            rx = {rx[6:0], serial_out_pin};
            repeat (4) @(posedge clk);
            sck <= 1'b0;
            repeat (4) @(posedge clk);
        end
        ssN <= 1'b1;
    endtask
endmodule

// ### test/tb_sps_serial_port.sv
`timescale 1ns/1ns
`include "sps_params.svh"
module tb_sps_serial_port;
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        sleepMode;
    logic        sck;
    logic        serial_in_pin;
    logic        ssN;
    logic        sdoOut;
    logic        sdoOe;
    logic        sckOut;
    logic        flag;
    logic        wake;
    logic [1:0]  modeNum;
    logic        iStart;
    logic        iStop;
    logic        iDone;
    logic [7:0]  iByte;
    logic        iData;
    logic        iMatch;
    logic        iRw;
    logic        iNack;
    logic        iUpd;
    logic        iTx;
    logic        sckOe;
    logic        idle;
    logic        slewOff;
    logic        smb;
    logic [7:0]  reload;
    logic [7:0]  q;
    logic [7:0]  rx;
    int          num_errors;
    int          compares;
    int          cycles;

    sps_serial_port sps_serial_port_inst (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sleepMode(sleepMode), .sckIn(sck), .sckOut(sckOut), .sckOe(sckOe), .sdiIn(serial_in_pin),
        .sdoOut(sdoOut), .sdoOe(sdoOe), .slaveSelN(ssN), .portIntFlag(flag), .wakeReq(wake),
        .spiModeNum(modeNum), .i2cStartSeen(iStart), .i2cStopSeen(iStop), .i2cNackSeen(iNack),
        .i2cByteDone(iDone), .i2cRxByte(iByte), .i2cByteIsData(iData), .i2cAddrMatch(iMatch),
        .i2cRwBit(iRw), .i2cAddrUpdate(iUpd), .i2cTxData(iTx), .i2cPortIdle(idle),
        .slewRateOff(slewOff), .smbusLevels(smb), .addrOrReload(reload)
    );
    // A released output shows the opposite level, never the last bit
    sps_spi_master_model sps_spi_master_model_inst (
        .clk(clk), .serial_out_pin(sdoOe ? sdoOut : ~sdoOut), .sck(sck), .serial_in_pin(serial_in_pin), .ssN(ssN)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        $display("Checks %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // One-cycle event: 0 start, 1 stop, 2 match, 3 byte done, 4 nack, 5 update
    task automatic pulse(input int k);
        iStart <= k == 0;
        iStop <= k == 1;
        iMatch <= k == 2;
        iDone <= k == 3;
        iNack <= k == 4;
        iUpd <= k == 5;
        @(posedge clk);
        {iStart, iStop, iMatch, iDone, iNack, iUpd} <= 6'h00;
        @(posedge clk);
    endtask

    task automatic t_reset();
        wb(0, `SPS_OFF_CON, 8'h00);
        chk("control", q, `SPS_CON_RST);
        wb(0, `SPS_OFF_STAT, 8'h00);
        chk("status", q, `SPS_STAT_RST);
        wb(0, 8'h18, 8'h00);
        chk("unmapped", q, 8'h00);
    endtask

    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            wb(1, `SPS_OFF_CON, {3'b001, i[1], `SPS_MODE_SLV_SS});
            wb(1, `SPS_OFF_STAT, {1'b0, ~i[0], 6'h00});
            chk("spiModeNum", {6'h0, modeNum}, i[7:0]);
        end
    endtask

    task automatic t_slave();
        wb(1, `SPS_OFF_STAT, 8'h40);
        wb(1, `SPS_OFF_CON, 8'h24);
        wb(1, `SPS_OFF_CTRL, 8'h03);
        wb(1, `SPS_OFF_BUF, 8'ha5);
        chk("sdoOe deselected", {7'h0, sdoOe}, 8'h00);
        sleepMode <= 1'b1;
        sps_spi_master_model_inst.xfer(8'h3c, 8, rx);
        chk("slave tx", rx, 8'ha5);
        repeat (4) @(posedge clk);
        chk("flag asleep", {7'h0, flag}, 8'h01);
        chk("wake", {7'h0, wake}, 8'h01);
        sleepMode <= 1'b0;
        wb(0, `SPS_OFF_STAT, 8'h00);
        chk("status full", q, 8'h41);
        wb(0, `SPS_OFF_BUF, 8'h00);
        chk("rx byte", q, 8'h3c);
        wb(0, `SPS_OFF_STAT, 8'h00);
        chk("status read", q, 8'h40);
    endtask

    task automatic t_abort();
        wb(1, `SPS_OFF_BUF, 8'hff);
        sps_spi_master_model_inst.xfer(8'h00, 3, rx);
        #1;
        chk("sdoOe released", {7'h0, sdoOe}, 8'h00);
        repeat (4) @(posedge clk);
        wb(1, `SPS_OFF_BUF, 8'h96);
        sps_spi_master_model_inst.xfer(8'h81, 8, rx);
        chk("tx after abort", rx, 8'h96);
        repeat (4) @(posedge clk);
        wb(0, `SPS_OFF_BUF, 8'h00);
        chk("rx after abort", q, 8'h81);
    endtask

    task automatic t_mode5();
        wb(1, `SPS_OFF_STAT, 8'h00);
        wb(1, `SPS_OFF_CON, 8'h25);
        chk("sdoOe pin ignored", {7'h0, sdoOe}, 8'h01);
        wb(1, `SPS_OFF_CTRL, 8'h05);
        chk("sdoOe as input", {7'h0, sdoOe}, 8'h00);
        sps_spi_master_model_inst.xfer(8'h5e, 8, rx);
        repeat (4) @(posedge clk);
        wb(0, `SPS_OFF_BUF, 8'h00);
        chk("rx as input", q, 8'h5e);
        wb(1, `SPS_OFF_CON, 8'h05);
        wb(1, `SPS_OFF_CTRL, 8'h00);
        chk("sdoOe disabled", {7'h0, sdoOe}, 8'h00);
    endtask

    task automatic t_sleep();
        logic frozen;
        wb(1, `SPS_OFF_CTRL, 8'h01);
        wb(1, `SPS_OFF_CON, 8'h21);
        wb(1, `SPS_OFF_BUF, 8'h00);
        // Long enough for the divider to reach its first clock edge
        repeat (40) @(posedge clk);
        sleepMode <= 1'b1;
        repeat (2) @(posedge clk);
        frozen = sckOut;
        // Five half periods: a running clock would end inverted
        repeat (40) @(posedge clk);
        chk("clock frozen", {7'h0, sckOut}, {7'h0, frozen});
        chk("no flag asleep", {7'h0, flag}, 8'h00);
        sleepMode <= 1'b0;
        for (int i = 0; i < 300 && flag !== 1'b1; i++) @(posedge clk);
        chk("resumed", {7'h0, flag}, 8'h01);
        wb(1, `SPS_OFF_BUF, 8'h00);
        repeat (6) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wb(0, `SPS_OFF_CON, 8'h00);
        chk("control after reset", q, 8'h00);
        chk("flag after reset", {7'h0, flag}, 8'h00);
        chk("sckOe after reset", {7'h0, sckOe}, 8'h00);
    endtask

    task automatic t_i2c();
        wb(1, `SPS_OFF_CON, 8'h26);
        wb(1, `SPS_OFF_STAT, 8'hff);
        wb(0, `SPS_OFF_STAT, 8'h00);
        chk("status writable", q, 8'hc0);
        chk("slew smbus", {6'h0, slewOff, smb}, 8'h03);
        wb(1, `SPS_OFF_STAT, 8'h40);
        chk("slew smbus", {6'h0, slewOff, smb}, 8'h01);
        pulse(0);
        iRw <= 1'b1;
        pulse(2);
        iByte <= 8'h77;
        iData <= 1'b1;
        pulse(3);
        wb(0, `SPS_OFF_STAT, 8'h00);
        chk("status data", q, 8'h6d);
        pulse(4);
        wb(0, `SPS_OFF_STAT, 8'h00);
        chk("status nack", q, 8'h69);
        pulse(1);
        wb(0, `SPS_OFF_STAT, 8'h00);
        chk("status stop", q, 8'h71);
        wb(0, `SPS_OFF_BUF, 8'h00);
        chk("i2c byte", q, 8'h77);
        wb(1, `SPS_OFF_CON, 8'h06);
        wb(0, `SPS_OFF_STAT, 8'h00);
        chk("stop start off", q & 8'h18, 8'h00);
        wb(1, `SPS_OFF_CON, 8'h27);
        pulse(5);
        wb(0, `SPS_OFF_STAT, 8'h00);
        chk("update addr", q & 8'h02, 8'h02);
        wb(1, `SPS_OFF_ADDR, 8'hff);
        chk("own address", reload, 8'hff);
        wb(1, `SPS_OFF_CON, 8'h28);
        chk("reload", reload, 8'h7f);
        chk("idle", {7'h0, idle}, 8'h01);
        iTx <= 1'b1;
        wb(0, `SPS_OFF_STAT, 8'h00);
        chk("tx status", q & 8'h05, 8'h05);
        chk("tx not idle", {7'h0, idle}, 8'h00);
        iTx <= 1'b0;
        wb(1, `SPS_OFF_CON2, 8'h10);
        chk("busy", {7'h0, idle}, 8'h00);
    endtask

    initial begin
        {cyc, stb, we, sleepMode, iStart, iStop, iDone, iData, iMatch, iRw, iNack, iUpd, iTx} = 13'h0000;
        adr = 8'h00;
        wdat = 32'h0;
        iByte = 8'h00;
        num_errors = 0;
        compares = 0;
        cycles = 0;
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_modes();
        t_slave();
        t_abort();
        t_mode5();
        t_sleep();
        t_i2c();
        test_done();
    end
endmodule
